/* File: rtl/mds_consts.svh */
// offsets, field positions, reset values and timing counts of the sync control block
`ifndef MDS_CONSTS_SVH
`define MDS_CONSTS_SVH

`define MDS_ADDR_DIGCTL_A 8'h01
`define MDS_ADDR_DIGCTL_B 8'h02
`define MDS_ADDR_CLKDIV_MARGIN 8'h03
`define MDS_ADDR_CLKDELAY_OUTDIV 8'h04
`define MDS_ADDR_OUTDELAY_INRATIO 8'h05
`define MDS_ADDR_INDELAY_MARGIN 8'h06
`define MDS_ADDR_ENABLES_STATE 8'h07

`define MDS_BIT_DCK_DLY_MSB 1
`define MDS_BIT_DCK_DLY_EN 4
`define MDS_BIT_SI_EN 7
`define MDS_BIT_SO_EN 6
`define MDS_BIT_SO_RISE 5

`define MDS_RST_BYTE 8'h00
`define MDS_RST_BIT 1'b0

`define MDS_CLK_PS 20000
`define MDS_DLY_STEP_PS 80
// a least time rounds up, and never below one cycle
`define MDS_DLY_STEP_CYC ((`MDS_DLY_STEP_PS + `MDS_CLK_PS - 1) / `MDS_CLK_PS)
`define MDS_SO_N_MAX 6'h20
`define MDS_GAP_MAX 4'hF

`endif

/* File: rtl/mds_delay_line.sv */
// tapped delay line whose selected tap comes out of a register
`timescale 1ns/1ns
module mds_delay_line #(
	parameter int TAPS = 32,
	parameter int STEP = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	input wire logic [4:0] sel_i,
	output logic q_o
);
	localparam int DEPTH = TAPS * STEP;
	logic [DEPTH-1:0] line_ff;
	logic [DEPTH-1:0] nxt_line;
	logic q_ff;
	logic nxt_q;

	// tap 0 is the nominal delay of two registers
	always_comb begin
		nxt_line = {line_ff[DEPTH-2:0], d_i};
		nxt_q = line_ff[int'(sel_i) * STEP];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_ff <= '0;
			q_ff <= 1'b0;
		end else begin
			line_ff <= nxt_line;
			q_ff <= nxt_q;
		end
	end

	assign q_o = q_ff;
endmodule

/* File: rtl/mds_pkg.sv */
// types shared by the sync control block
package mds_pkg;
	typedef struct packed {
		logic [1:0] dck_div;
		logic [3:0] data_margin;
		logic [4:0] dck_delay;
		logic dck_dly_en;
		logic [2:0] so_div;
		logic [4:0] so_delay;
		logic [2:0] si_ratio;
		logic [4:0] si_delay;
		logic [3:0] si_margin;
		logic si_en;
		logic so_en;
		logic so_rise;
		logic [4:0] clk_state;
	} mds_cfg_s;

	typedef enum logic [1:0] {
		MDS_SO_IDLE = 2'b01,
		MDS_SO_ARMED = 2'b10
	} mds_so_e;
endpackage

/* File: rtl/mds_sync_ctrl.sv */
// data-clock divider/delay, sync output generator and sync input qualifier
`timescale 1ns/1ns
`include "mds_consts.svh"

module mds_sync_ctrl
	import mds_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic reference_clock_in_i,
	input wire logic sync_in_i,
	input wire logic data_edge_i,
	output logic source_word_clock_out_o,
	output logic sync_out_o,
	output logic sync_event_o,
	output logic [4:0] clock_state_o,
	output logic data_timing_err_o,
	output logic sync_timing_err_o
);
	// register bytes
	logic dck_msb_ff, nxt_dck_msb;
	logic dck_en_ff, nxt_dck_en;
	logic [7:0] r03_ff, nxt_r03, r04_ff, nxt_r04, r05_ff, nxt_r05, r06_ff, nxt_r06, r07_ff, nxt_r07;
	logic [7:0] rdata_ff, nxt_rdata;
	mds_cfg_s cfg;

	// clocking and sync state
	logic ref_prev_ff, nxt_ref_prev;
	logic [1:0] dck_cnt_ff, nxt_dck_cnt;
	logic [4:0] so_cnt_ff, nxt_so_cnt;
	mds_so_e so_state_ff, nxt_so_state;
	logic so_pulse_ff, nxt_so_pulse;
	logic si_prev_ff, nxt_si_prev;
	logic [2:0] si_cnt_ff, nxt_si_cnt;
	logic event_ff, nxt_event;
	logic [4:0] state_ff, nxt_state;
	logic dck_prev_ff, nxt_dck_prev;
	logic [3:0] dgap_ff, nxt_dgap, rgap_ff, nxt_rgap;
	logic derr_ff, nxt_derr, serr_ff, nxt_serr;

	logic ref_rise, ref_fall, so_tick, dck_raw, si_dly, si_rise, dck_rise;
	logic [4:0] dck_sel;

	// sync output period N for a divide code; undefined codes fall back to 32
	function automatic logic [5:0] so_period(input logic [2:0] code);
		so_period = (code <= 3'h5) ? (`MDS_SO_N_MAX >> code) : `MDS_SO_N_MAX;
	endfunction

	// saturating gap counter, shared by both margin checks
	function automatic logic [3:0] gap_step(input logic restart, input logic [3:0] gap);
		gap_step = restart ? 4'h0 : ((gap == `MDS_GAP_MAX) ? gap : gap + 4'h1);
	endfunction

	// field unpacking; split delay codes are joined from two registers
	always_comb begin
		cfg.dck_div = r03_ff[5:4];
		cfg.data_margin = r03_ff[3:0];
		cfg.dck_delay = {dck_msb_ff, r04_ff[7:4]};
		cfg.dck_dly_en = dck_en_ff;
		cfg.so_div = r04_ff[3:1];
		cfg.so_delay = {r04_ff[0], r05_ff[7:4]};
		cfg.si_ratio = r05_ff[3:1];
		cfg.si_delay = {r05_ff[0], r06_ff[7:4]};
		cfg.si_margin = r06_ff[3:0];
		cfg.si_en = r07_ff[`MDS_BIT_SI_EN];
		cfg.so_en = r07_ff[`MDS_BIT_SO_EN];
		cfg.so_rise = r07_ff[`MDS_BIT_SO_RISE];
		cfg.clk_state = r07_ff[4:0];
	end

	// register writes and registered read data; unmapped offsets read zero
	always_comb begin
		nxt_dck_msb = dck_msb_ff;
		nxt_dck_en = dck_en_ff;
		nxt_r03 = r03_ff;
		nxt_r04 = r04_ff;
		nxt_r05 = r05_ff;
		nxt_r06 = r06_ff;
		nxt_r07 = r07_ff;
		nxt_rdata = rdata_ff;
		if (reg_wr_i) begin
			case (reg_addr_i)
				`MDS_ADDR_DIGCTL_A: nxt_dck_msb = reg_wdata_i[`MDS_BIT_DCK_DLY_MSB];
				`MDS_ADDR_DIGCTL_B: nxt_dck_en = reg_wdata_i[`MDS_BIT_DCK_DLY_EN];
				`MDS_ADDR_CLKDIV_MARGIN: nxt_r03 = reg_wdata_i; // bits 7:6 kept as written by software
				`MDS_ADDR_CLKDELAY_OUTDIV: nxt_r04 = reg_wdata_i;
				`MDS_ADDR_OUTDELAY_INRATIO: nxt_r05 = reg_wdata_i;
				`MDS_ADDR_INDELAY_MARGIN: nxt_r06 = reg_wdata_i;
				`MDS_ADDR_ENABLES_STATE: nxt_r07 = reg_wdata_i;
				default: ;
			endcase
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				`MDS_ADDR_DIGCTL_A: nxt_rdata = 8'(dck_msb_ff) << `MDS_BIT_DCK_DLY_MSB;
				`MDS_ADDR_DIGCTL_B: nxt_rdata = 8'(dck_en_ff) << `MDS_BIT_DCK_DLY_EN;
				`MDS_ADDR_CLKDIV_MARGIN: nxt_rdata = r03_ff;
				`MDS_ADDR_CLKDELAY_OUTDIV: nxt_rdata = r04_ff;
				`MDS_ADDR_OUTDELAY_INRATIO: nxt_rdata = r05_ff;
				`MDS_ADDR_INDELAY_MARGIN: nxt_rdata = r06_ff;
				`MDS_ADDR_ENABLES_STATE: nxt_rdata = r07_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dck_msb_ff <= `MDS_RST_BIT;
			dck_en_ff <= `MDS_RST_BIT;
			r03_ff <= `MDS_RST_BYTE;
			r04_ff <= `MDS_RST_BYTE;
			r05_ff <= `MDS_RST_BYTE;
			r06_ff <= `MDS_RST_BYTE;
			r07_ff <= `MDS_RST_BYTE;
			rdata_ff <= 8'h00;
		end else begin
			dck_msb_ff <= nxt_dck_msb;
			dck_en_ff <= nxt_dck_en;
			r03_ff <= nxt_r03;
			r04_ff <= nxt_r04;
			r05_ff <= nxt_r05;
			r06_ff <= nxt_r06;
			r07_ff <= nxt_r07;
			rdata_ff <= nxt_rdata;
		end
	end

	// reference edges; the reference input is already synchronous to clk_i
	assign ref_rise = reference_clock_in_i & ~ref_prev_ff;
	assign ref_fall = ~reference_clock_in_i & ref_prev_ff;
	assign so_tick = ({1'b0, so_cnt_ff} == so_period(cfg.so_div) - 6'h01);
	assign si_rise = si_dly & ~si_prev_ff;
	assign dck_rise = source_word_clock_out_o & ~dck_prev_ff;
	// delay bypassed while disabled, so a stale code cannot skew the data clock
	assign dck_sel = cfg.dck_dly_en ? cfg.dck_delay : 5'h00;

	// data clock divider built on reference rising edges
	always_comb begin
		nxt_ref_prev = reference_clock_in_i;
		nxt_dck_cnt = ref_rise ? dck_cnt_ff + 2'h1 : dck_cnt_ff;
		case (cfg.dck_div)
			2'b01: dck_raw = dck_cnt_ff[0];
			2'b10: dck_raw = dck_cnt_ff[1];
			default: dck_raw = reference_clock_in_i;
		endcase
	end

	// sync output: divide the DAC clock, then release on the chosen reference edge
	always_comb begin
		nxt_so_cnt = so_tick ? 5'h00 : so_cnt_ff + 5'h01;
		nxt_so_state = so_state_ff;
		nxt_so_pulse = 1'b0;
		case (so_state_ff)
			MDS_SO_IDLE: begin
				if (so_tick && cfg.so_en) begin
					nxt_so_state = MDS_SO_ARMED;
				end
			end
			MDS_SO_ARMED: begin
				if (!cfg.so_en) begin
					nxt_so_state = MDS_SO_IDLE;
				end else if (cfg.so_rise ? ref_rise : ref_fall) begin
					nxt_so_pulse = 1'b1;
					nxt_so_state = MDS_SO_IDLE;
				end
			end
			default: nxt_so_state = MDS_SO_IDLE;
		endcase
	end

	// sync input qualification and clock state machine load
	always_comb begin
		nxt_si_prev = si_dly;
		nxt_si_cnt = si_cnt_ff;
		nxt_event = 1'b0;
		nxt_state = state_ff + 5'h01;
		if (cfg.si_en && si_rise) begin
			if (si_cnt_ff >= cfg.si_ratio) begin
				nxt_si_cnt = 3'h0;
				nxt_event = 1'b1;
				nxt_state = cfg.clk_state;
			end else begin
				nxt_si_cnt = si_cnt_ff + 3'h1;
			end
		end
	end

	// timing margin checks, each judged at the moment it matters
	always_comb begin
		nxt_dck_prev = source_word_clock_out_o;
		nxt_dgap = gap_step(data_edge_i, dgap_ff);
		nxt_rgap = gap_step(ref_rise, rgap_ff);
		nxt_derr = derr_ff;
		nxt_serr = serr_ff;
		if (dck_rise) begin
			nxt_derr = (dgap_ff < cfg.data_margin);
		end
		if (cfg.si_en && si_rise) begin
			nxt_serr = (rgap_ff < cfg.si_margin);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_prev_ff <= 1'b0;
			dck_cnt_ff <= 2'h0;
			so_cnt_ff <= 5'h00;
			so_state_ff <= MDS_SO_IDLE;
			so_pulse_ff <= 1'b0;
			si_prev_ff <= 1'b0;
			si_cnt_ff <= 3'h0;
			event_ff <= 1'b0;
			state_ff <= 5'h00;
			dck_prev_ff <= 1'b0;
			dgap_ff <= 4'h0;
			rgap_ff <= 4'h0;
			derr_ff <= 1'b0;
			serr_ff <= 1'b0;
		end else begin
			ref_prev_ff <= nxt_ref_prev;
			dck_cnt_ff <= nxt_dck_cnt;
			so_cnt_ff <= nxt_so_cnt;
			so_state_ff <= nxt_so_state;
			so_pulse_ff <= nxt_so_pulse;
			si_prev_ff <= nxt_si_prev;
			si_cnt_ff <= nxt_si_cnt;
			event_ff <= nxt_event;
			state_ff <= nxt_state;
			dck_prev_ff <= nxt_dck_prev;
			dgap_ff <= nxt_dgap;
			rgap_ff <= nxt_rgap;
			derr_ff <= nxt_derr;
			serr_ff <= nxt_serr;
		end
	end

	// the three delay lines; one step is at least one clock cycle at this rate
	mds_delay_line #(.TAPS(32), .STEP(`MDS_DLY_STEP_CYC)) u_dck_dly (
		.clk_i(clk_i), .rst_i(rst_i), .d_i(dck_raw), .sel_i(dck_sel), .q_o(source_word_clock_out_o)
	);
	mds_delay_line #(.TAPS(32), .STEP(`MDS_DLY_STEP_CYC)) u_so_dly (
		.clk_i(clk_i), .rst_i(rst_i), .d_i(so_pulse_ff), .sel_i(cfg.so_delay), .q_o(sync_out_o)
	);
	mds_delay_line #(.TAPS(32), .STEP(`MDS_DLY_STEP_CYC)) u_si_dly (
		.clk_i(clk_i), .rst_i(rst_i), .d_i(sync_in_i), .sel_i(cfg.si_delay), .q_o(si_dly)
	);

	assign reg_rdata_o = rdata_ff;
	assign sync_event_o = event_ff;
	assign clock_state_o = state_ff;
	assign data_timing_err_o = derr_ff;
	assign sync_timing_err_o = serr_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_so_armed;
		so_state_ff == MDS_SO_ARMED;
	endsequence
	sequence s_so_fire;
		so_pulse_ff ##0 so_state_ff == MDS_SO_IDLE;
	endsequence

	a_dck_div_count: assert property (ref_rise |=> dck_cnt_ff == $past(dck_cnt_ff) + 2'h1)
		else $error("data clock divider did not advance");
	a_data_margin_flag: assert property ((dck_rise && dgap_ff < cfg.data_margin) |=> data_timing_err_o)
		else $error("data margin violation not flagged");
	a_so_period: assert property ((so_tick && so_period(cfg.so_div) > 6'h01) |=> !so_tick)
		else $error("sync output divider ticked too early");
	a_so_enable_gate: assert property (so_pulse_ff |-> $past(cfg.so_en) && $past(so_state_ff) == MDS_SO_ARMED)
		else $error("sync output pulse while disabled");
	a_so_edge_select: assert property (s_so_armed ##1 s_so_fire |-> $past(cfg.so_rise ? ref_rise : ref_fall))
		else $error("sync output released on wrong reference edge");
	a_si_ignored: assert property (!cfg.si_en |=> !sync_event_o)
		else $error("sync input accepted while disabled");
	a_si_ratio_count: assert property (sync_event_o |-> $past(si_cnt_ff) >= $past(cfg.si_ratio))
		else $error("sync event before ratio reached");
	a_state_load: assert property (sync_event_o |-> clock_state_o == $past(cfg.clk_state))
		else $error("clock state not loaded on sync");
	a_dck_dly_bypass: assert property (!cfg.dck_dly_en |=> source_word_clock_out_o == $past(dck_raw, 2))
		else $error("data clock delay active while disabled");
	a_si_margin_flag: assert property ((cfg.si_en && si_rise && rgap_ff < cfg.si_margin) |=> sync_timing_err_o)
		else $error("sync margin violation not flagged");
endmodule

/* File: sim/mds_peer_model.sv */
// behavioural source and peer: reference clock, data edges and sync input pulses
`timescale 1ns/1ns
module mds_peer_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] half_i,
	input wire logic send_i,
	output logic reference_clock_in_o,
	output logic sync_in_o,
	output logic data_edge_o
);
	logic [7:0] cnt_ff;
	// reference flips every half_i cycles, so the bench can run it fast or slow
	always @(posedge clk_i) begin
		data_edge_o <= 1'b0;
		sync_in_o <= send_i & ~rst_i;
		if (rst_i) begin
			cnt_ff <= 8'h00;
			reference_clock_in_o <= 1'b0;
		end else if (cnt_ff + 8'h01 >= half_i) begin
			cnt_ff <= 8'h00;
			reference_clock_in_o <= ~reference_clock_in_o;
			// the source launches a new word on each reference rise
			data_edge_o <= ~reference_clock_in_o;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end
endmodule

/* File: sim/multi_dac_sync_control_tb.sv */
// self-checking bench for the sync control block
`timescale 1ns/1ns
module multi_dac_sync_control_tb;
	logic clk_i, rst_i, reg_wr, reg_rd, send, ref_clk, sync_in, data_edge, dck, sync_out, sync_event, derr, serr;
	logic pr, ps, dck_q;
	logic [7:0] addr, wdata, rdata, half, rv;
	logic [4:0] cstate, ev_state;
	int error_cnt, n_compared, cycles, a, b, lat0;
	int since_ref, since_si, dck_rises, dck_lat, so_cnt, so_lat, ev_cnt, ev_lat;
	logic [7:0] ta [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08};
	logic [7:0] tw [7] = '{8'hFF, 8'hFF, 8'h5A, 8'hA5, 8'h5A, 8'hC3, 8'hFF};
	logic [7:0] te [7] = '{8'h02, 8'h10, 8'h5A, 8'hA5, 8'h5A, 8'hC3, 8'h00};
	int ed [4] = '{20, 10, 5, 20};

	mds_sync_ctrl u_mds_sync_ctrl (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .reference_clock_in_i(ref_clk),
		.sync_in_i(sync_in), .data_edge_i(data_edge), .source_word_clock_out_o(dck), .sync_out_o(sync_out),
		.sync_event_o(sync_event), .clock_state_o(cstate), .data_timing_err_o(derr), .sync_timing_err_o(serr));
	mds_peer_model u_mds_peer_model (.clk_i(clk_i), .rst_i(rst_i), .half_i(half), .send_i(send),
		.reference_clock_in_o(ref_clk), .sync_in_o(sync_in), .data_edge_o(data_edge));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk_i);
		addr <= ad;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_i);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] ad, output logic [7:0] d);
		@(posedge clk_i);
		addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk_i);
		reg_rd <= 1'b0;
		// read data is registered at the read edge and holds, so take it one edge later
		@(posedge clk_i);
		d = rdata;
	endtask

	// one peer sync pulse two cycles wide, then time for the delayed edge to land
	task pulse;
		@(posedge clk_i);
		send <= 1'b1;
		repeat (2) @(posedge clk_i);
		send <= 1'b0;
		repeat (50) @(posedge clk_i);
	endtask

	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// monitor: latencies are measured from the last reference rise or sync input rise
	always @(posedge clk_i) begin
		pr <= ref_clk;
		ps <= sync_in;
		dck_q <= dck;
		cycles <= cycles + 1;
		since_ref <= (ref_clk === 1'b1 && pr === 1'b0) ? 0 : since_ref + 1;
		since_si <= (sync_in === 1'b1 && ps === 1'b0) ? 0 : since_si + 1;
		if (dck === 1'b1 && dck_q === 1'b0) begin
			dck_rises <= dck_rises + 1;
			dck_lat <= since_ref;
		end
		if (sync_out === 1'b1) begin
			so_cnt <= so_cnt + 1;
			so_lat <= since_ref;
		end
		if (sync_event === 1'b1) begin
			ev_cnt <= ev_cnt + 1;
			ev_lat <= since_si;
			ev_state <= cstate;
		end
		// run takes about 14000 cycles; a hang stops here
		if (cycles == 40000) begin
			error_cnt++;
			wrap_up();
		end
	end

	initial begin
		{reg_wr, reg_rd, send, pr, ps, dck_q} = '0;
		{addr, wdata} = '0;
		{error_cnt, n_compared, cycles, since_ref, since_si, dck_rises, dck_lat, so_cnt, so_lat} = '0;
		{ev_cnt, ev_lat} = '0;
		half = 8'h28;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values, then masked and unmapped places
		for (a = 1; a <= 8; a++) begin
			rd(a[7:0], rv);
			check(rv, 8'h00);
		end
		for (a = 0; a < 7; a++) begin
			wr(ta[a], tw[a]);
			rd(ta[a], rv);
			check(rv, te[a]);
		end
		for (a = 1; a <= 7; a++) wr(a[7:0], (a == 3) ? 8'h40 : 8'h00);
		// data clock divider codes
		for (a = 0; a < 4; a++) begin
			wr(8'h03, {2'b01, a[1:0], 4'h0});
			repeat (80) @(posedge clk_i);
			b = dck_rises;
			repeat (1600) @(posedge clk_i);
			check((dck_rises - b >= ed[a] - 1) && (dck_rises - b <= ed[a] + 1), 1);
		end
		// data clock delay: ignored until enabled, MSB held apart
		wr(8'h03, 8'h40);
		repeat (200) @(posedge clk_i);
		lat0 = dck_lat;
		wr(8'h04, 8'h30);
		repeat (200) @(posedge clk_i);
		check(dck_lat, lat0);
		wr(8'h02, 8'h10);
		repeat (200) @(posedge clk_i);
		check(dck_lat, lat0 + 3);
		wr(8'h01, 8'h02);
		repeat (200) @(posedge clk_i);
		check(dck_lat, lat0 + 19);
		check(derr, 1'b0);
		// a long data clock delay leaves the saturated gap of 15, which meets the widest margin
		wr(8'h03, 8'h4F);
		repeat (200) @(posedge clk_i);
		check(derr, 1'b0);
		// a short delay leaves only a few cycles after the data edge, too little margin
		wr(8'h01, 8'h00);
		repeat (200) @(posedge clk_i);
		check(derr, 1'b1);
		wr(8'h02, 8'h00);
		wr(8'h04, 8'h00);
		wr(8'h03, 8'h40);
		// sync output: disabled, then edge choice and delay
		wr(8'h07, 8'h20);
		b = so_cnt;
		repeat (400) @(posedge clk_i);
		check(so_cnt, b);
		wr(8'h07, 8'h60);
		repeat (300) @(posedge clk_i);
		lat0 = so_lat;
		wr(8'h07, 8'h40);
		repeat (300) @(posedge clk_i);
		check(so_lat, lat0 + 40);
		wr(8'h05, 8'h50);
		repeat (300) @(posedge clk_i);
		check(so_lat, lat0 + 45);
		wr(8'h04, 8'h01);
		repeat (300) @(posedge clk_i);
		check(so_lat, lat0 + 61);
		wr(8'h05, 8'h00);
		// sync output rate for N of 32, 16, 8, 4 with a fast reference
		half <= 8'h01;
		wr(8'h07, 8'h60);
		for (a = 0; a < 4; a++) begin
			wr(8'h04, {4'h0, a[2:0], 1'b0});
			repeat (100) @(posedge clk_i);
			b = so_cnt;
			repeat (640) @(posedge clk_i);
			check((so_cnt - b >= (20 << a) - 2) && (so_cnt - b <= (20 << a) + 2), 1);
		end
		// an undefined divide code falls back to the slowest rate
		wr(8'h04, 8'h0C);
		repeat (100) @(posedge clk_i);
		b = so_cnt;
		repeat (640) @(posedge clk_i);
		check((so_cnt - b >= 18) && (so_cnt - b <= 22), 1);
		// sync input: state load, delay, margin, ratio, enable
		wr(8'h04, 8'h00);
		wr(8'h07, 8'h95);
		pulse();
		check(ev_state, 5'h15);
		check(serr, 1'b0);
		lat0 = ev_lat;
		wr(8'h06, 8'h5F);
		pulse();
		check(ev_lat, lat0 + 5);
		check(serr, 1'b1);
		wr(8'h05, 8'h01);
		pulse();
		check(ev_lat, lat0 + 21);
		wr(8'h06, 8'h00);
		wr(8'h05, 8'h04);
		b = ev_cnt;
		pulse();
		pulse();
		check(ev_cnt, b);
		pulse();
		check(ev_cnt, b + 1);
		wr(8'h07, 8'h15);
		for (a = 0; a < 3; a++) pulse();
		check(ev_cnt, b + 1);
		wrap_up();
	end
endmodule
